// [bench/tb.sv]
`timescale 1ns/10ps
`include "tmw_regs.svh"
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        ddr_out_a = 1'b0;
  logic        ddr_out_b = 1'b0;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h08CB;
  logic [3:0]  md [4] = '{4'h4, 4'hF, 4'h9, 4'hB};
  int          pe [4] = '{10, 10, 18, 18};
  int          q [$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  wire         pready, pslverr, irq;
  wire  [31:0] prdata;
  wire         compare_out_a, compare_out_a_oe, compare_out_a_sel;
  wire         compare_out_b, compare_out_b_oe, compare_out_b_sel;

  tmw_timer uut (.*);

  always #2.5 pclk = ~pclk;

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic finish_test();
    $display("Checks done %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic timeout(input string m);
    n_mismatch++;
    $display("MISMATCH %0t no response on %s", $time, m);
    finish_test();
  endtask

  // Read data is taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) timeout("pready");
    rdata = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // High bits first, so no transient passes through the reserved mode
  task automatic set_mode(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab);
    apb(1'b1, `TMW_CTRL_B_OFF, {30'h0, m[3:2]});
    apb(1'b1, `TMW_CTRL_A_OFF, {24'h0, aa, ab, 2'b00, m[1:0]});
    apb(1'b1, `TMW_CNT_OFF, 32'h0);
  endtask

  task automatic period(output int p);
    logic v;
    int   i;
    v = compare_out_a;
    i = 0;
    while (compare_out_a === v && i < 2000) begin
      @(posedge pclk);
      i++;
    end
    v = compare_out_a;
    p = 0;
    while (compare_out_a === v && p < 2000) begin
      @(posedge pclk);
      p++;
    end
    if (p >= 2000) timeout("toggle");
  endtask

  task automatic count_high(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge pclk);
      if (compare_out_b === 1'b1) h++;
    end
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    int          p, h, e, c, act, top;
    logic [31:0] w;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TMW_CTRL_A_OFF, 32'h0);
    chk(rdata, 32'h0, "control reset");
    repeat (4) begin
      w = rnd();
      ddr_out_a <= w[8];
      ddr_out_b <= w[9];
      q.push_back(int'(w & 32'h0000_00F3));
      apb(1'b1, `TMW_CTRL_A_OFF, w);
      apb(1'b0, `TMW_CTRL_A_OFF, 32'h0);
      chk(rdata, q.pop_front(), "control readback");
    end
    w = rnd();
    apb(1'b1, 12'hFFC, w);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(rdata, 32'h0, "unmapped read");
    chk(pslverr, 1'b0, "error response");
    $display("Test registers finished");
    ddr_out_a <= 1'b1;
    ddr_out_b <= 1'b1;
    apb(1'b1, `TMW_CMPA_OFF, 32'h9);
    foreach (md[i]) begin
      set_mode(md[i], 2'b01, 2'b00);
      repeat (40) @(posedge pclk);
      period(p);
      chk(p, pe[i], "toggle period");
    end
    for (int a = 2; a < 4; a++) begin
      set_mode(4'h4, a[1:0], 2'b00);
      repeat (30) @(posedge pclk);
      chk(compare_out_a, a[0], "match level");
    end
    $display("Test toggle finished");
    for (int m = 5; m < 8; m++) begin
      top = (256 << (m - 5)) - 1;
      for (int k = 0; k < 4; k++) begin
        c = k[1] ? top : 64;
        act = 2 + k[0];
        apb(1'b1, `TMW_CMPB_OFF, c);
        set_mode(m[3:0], 2'b01, act[1:0]);
        repeat (2 * top + 20) @(posedge pclk);
        count_high(top + 1, h);
        e = (c == top) ? ((act == 2) ? top + 1 : 0) : ((act == 2) ? c + 1 : top - c);
        chk(h, e, "fast duty");
      end
    end
    $display("Test fast finished");
    for (int k = 0; k < 6; k++) begin
      c = (k % 3 == 0) ? 0 : ((k % 3 == 1) ? 85 : 255);
      act = 2 + k / 3;
      apb(1'b1, `TMW_CMPB_OFF, c);
      set_mode(4'h1, 2'b00, act[1:0]);
      repeat (1100) @(posedge pclk);
      count_high(510, h);
      e = (act == 2) ? 2 * c : 510 - 2 * c;
      chk(h, e, "dual duty");
    end
    $display("Test dual finished");
    apb(1'b1, `TMW_PRESC_OFF, 32'h0000_FFFF);
    apb(1'b1, `TMW_MASK_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, `TMW_MASK_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1, "irq raised");
    apb(1'b0, `TMW_STAT_OFF, 32'h0);
    chk(rdata & 32'h1, 32'h1, "overflow flag");
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    apb(1'b0, `TMW_STAT_OFF, 32'h0);
    chk(rdata, 32'h0, "status cleared");
    $display("Test interrupt finished");
    finish_test();
  end
endmodule

// [bench/tmw_timer_properties.sv]
`timescale 1ns/10ps
`include "tmw_regs.svh"
module tmw_timer_chk (
  // Bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // Pins
  input wire logic        ddr_out_a,
  input wire logic        ddr_out_b,
  input wire logic        compare_out_a_oe,
  input wire logic        compare_out_a_sel,
  input wire logic        compare_out_b_oe,
  input wire logic        compare_out_b_sel
);
  // ------
  // Shadow of the control fields
  // ------
  logic [7:0] ctl_reg, ctl_next;
  logic [1:0] hi_reg, hi_next;
  logic       acc, pwm, a_on, a_off, b_off, a_tg, b_tg, rd_a;
  logic [3:0] mode;
  assign acc   = psel && penable && pready;
  assign rd_a  = acc && !pwrite && paddr == `TMW_CTRL_A_OFF;
  assign mode  = {hi_reg, ctl_reg[1:0]};
  // Mode 13 is left out: its output behaviour is undefined
  assign pwm   = mode inside {[4'h1:4'h3], [4'h5:4'hB], 4'hE, 4'hF};
  assign a_on  = ctl_reg[7] && mode != 4'hD;
  assign a_off = ctl_reg[7:6] == 2'b00;
  assign b_off = ctl_reg[5:4] == 2'b00;
  assign a_tg  = ctl_reg[7:6] == 2'b01 && pwm && !mode[3];
  assign b_tg  = ctl_reg[5:4] == 2'b01 && pwm;
  always_comb begin
    ctl_next = ctl_reg;
    hi_next  = hi_reg;
    if (acc && pwrite && paddr == `TMW_CTRL_A_OFF) ctl_next = pwdata[7:0] & 8'hF3;
    if (acc && pwrite && paddr == `TMW_CTRL_B_OFF) hi_next = pwdata[1:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= 8'h00;
      hi_reg  <= 2'h0;
    end else begin
      ctl_reg <= ctl_next;
      hi_reg  <= hi_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_oe_a_dir: assert property (
    compare_out_a_oe |-> compare_out_a_sel && $past(ddr_out_a, 2))
    else $error("A driven without select or direction");
  chk_oe_b_dir: assert property (
    compare_out_b_oe |-> compare_out_b_sel && $past(ddr_out_b, 2))
    else $error("B driven without select or direction");
  chk_sel_a_on: assert property (
    a_on [*3] |-> compare_out_a_sel)
    else $error("A action set but pin not taken");
  chk_sel_a_off: assert property (
    $past(a_off) && $past(a_off, 2) |-> !compare_out_a_sel)
    else $error("A pin taken with action zero");
  chk_sel_b_off: assert property (
    b_off [*3] |-> !compare_out_b_sel)
    else $error("B pin taken with action zero");
  chk_a_tog_off: assert property (
    $past(a_tg) && $past(a_tg, 2) |-> !compare_out_a_sel)
    else $error("A toggle connected in fixed ceiling mode");
  chk_b_tog_off: assert property (
    b_tg [*3] |-> !compare_out_b_sel)
    else $error("B toggle connected in a PWM mode");
  chk_read_ctl: assert property (
    rd_a |-> prdata == {24'h000000, ctl_reg})
    else $error("control readback wrong");
endmodule

bind tmw_timer tmw_timer_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
  .ddr_out_a, .ddr_out_b, .compare_out_a_oe, .compare_out_a_sel,
  .compare_out_b_oe, .compare_out_b_sel
);

// [rtl/tmw_channel.sv]
`timescale 1ns/10ps
// One compare output channel: reacts to match and ceiling events
module tmw_channel (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [1:0] action,
  input  wire logic       is_chan_a,
  input  wire logic [3:0] mode,
  input  wire logic [3:0] seq,
  // Events, valid with tick
  input  wire logic       tick,
  input  wire logic       match,
  input  wire logic       at_top,
  input  wire logic       counting_up,
  input  wire logic       cmp_is_top,
  input  wire logic       cmp_is_floor,
  input  wire logic       ddr_out,
  // Results
  output logic            level,
  output logic            connect,
  output logic            drive_en
);
  logic level_reg;
  logic level_next;
  logic toggle_ok;

  always_comb begin
    level_next = level_reg;
    toggle_ok  = 1'b0;
    case (seq)
      tmw_pkg::TMW_SEQ_UP: begin
        toggle_ok = 1'b1;
        if (tick && match) begin
          case (action)
            2'b01:   level_next = ~level_reg;
            2'b10:   level_next = 1'b0;
            2'b11:   level_next = 1'b1;
            default: level_next = level_reg;
          endcase
        end
      end
      tmw_pkg::TMW_SEQ_FAST: begin
        toggle_ok = is_chan_a && (mode == 4'hE || mode == 4'hF);
        if (tick) begin
          if (action == 2'b01 && toggle_ok && match)
            level_next = ~level_reg;
          else if (action[1] && at_top)
            level_next = ~action[0];
          else if (action[1] && match && !cmp_is_top)
            level_next = action[0];
        end
      end
      tmw_pkg::TMW_SEQ_DUAL: begin
        toggle_ok = is_chan_a && (mode >= 4'h8) && (mode <= 4'hB);
        if (tick) begin
          if (action == 2'b01 && toggle_ok && match)
            level_next = ~level_reg;
          else if (action[1] && cmp_is_floor)
            level_next = action[0];
          else if (action[1] && cmp_is_top)
            level_next = ~action[0];
          else if (action[1] && match)
            level_next = counting_up ? action[0] : ~action[0];
        end
      end
      default: level_next = level_reg;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
      connect   <= 1'b0;
      drive_en  <= 1'b0;
    end else begin
      level_reg <= level_next;
      connect   <= action[1] || (action[0] && toggle_ok);
      drive_en  <= ddr_out;
    end
  end

  assign level = level_reg;
endmodule

// [rtl/tmw_pkg.sv]
package tmw_pkg;
  typedef enum logic [3:0] {
    TMW_SEQ_UP   = 4'h1,
    TMW_SEQ_FAST = 4'h2,
    TMW_SEQ_DUAL = 4'h4,
    TMW_SEQ_NONE = 4'h8
  } tmw_seq_e;
  typedef enum logic [1:0] {
    TMW_TOP_FIXED = 2'h0,
    TMW_TOP_CMPA  = 2'h1,
    TMW_TOP_CAP   = 2'h2
  } tmw_topsrc_e;
  typedef enum logic [1:0] {
    TMW_RELOAD_NOW   = 2'h0,
    TMW_RELOAD_TOP   = 2'h1,
    TMW_RELOAD_FLOOR = 2'h2
  } tmw_reload_e;
endpackage

// [rtl/tmw_regs.svh]
`ifndef TMW_REGS_SVH
`define TMW_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define TMW_CTRL_A_OFF     12'h000
`define TMW_CTRL_B_OFF     12'h004
`define TMW_CNT_OFF        12'h008
`define TMW_CMPA_OFF       12'h00C
`define TMW_CMPB_OFF       12'h010
`define TMW_CAP_OFF        12'h014
`define TMW_STAT_OFF       12'h018
`define TMW_MASK_OFF       12'h01C
`define TMW_PRESC_OFF      12'h020
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define TMW_ACT_A_HI       7
`define TMW_ACT_A_LO       6
`define TMW_ACT_B_HI       5
`define TMW_ACT_B_LO       4
`define TMW_CTRL_A_MASK    8'hF3
`define TMW_CTRL_A_RST     8'h00
`define TMW_STAT_OVF       0
`define TMW_STAT_MATCH_A   1
`define TMW_STAT_MATCH_B   2
`define TMW_MAX            16'hFFFF
`define TMW_FLOOR          16'h0000
`define TMW_TOP_8BIT       16'h00FF
`define TMW_TOP_9BIT       16'h01FF
`define TMW_TOP_10BIT      16'h03FF
`define TMW_PRESC_RST      16'h0000
`endif

// [rtl/tmw_timer.sv]
`timescale 1ns/10ps
`include "tmw_regs.svh"
// Functional notes
// - Action field 2 or 3 takes over the pin; action 1 only where toggle is allowed
// - Pin driven only when direction is output
// - Non-PWM: toggle, clear, set on match
// - Fast PWM toggle only A, modes 14-15
// - Fast PWM: match clears/sets, ceiling opposite
// - Fast PWM: clear/set match at ceiling ignored; toggle (A, modes 14-15) still fires there
// - Dual-slope toggle only A, modes 8-11
// - Dual-slope: up and down matches opposite
// - Mode is four bits over two registers
// - Normal and clear-on-match ceilings, immediate reload
// - Phase-correct ceilings, reload at ceiling, overflow at floor
// - Fast PWM ceilings, reload and overflow at ceiling
// - Modes 8-9 reload and overflow at floor
// - Dual-slope up/down, ceiling held one tick
// - Dual-slope: clear/set with floor/ceiling compare gives constant level
module tmw_timer (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Pin direction bits
  input  wire logic        ddr_out_a,
  input  wire logic        ddr_out_b,
  // Compare output pins
  output logic             compare_out_a,
  output logic             compare_out_a_oe,
  output logic             compare_out_a_sel,
  output logic             compare_out_b,
  output logic             compare_out_b_oe,
  output logic             compare_out_b_sel,
  // Interrupt
  output logic             irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  timer_waveform_control_a_reg;
  logic [7:0]  timer_waveform_control_a_next;
  logic [1:0]  mode_hi_reg;
  logic [1:0]  mode_hi_next;
  logic [15:0] counter_value_reg;
  logic [15:0] counter_value_next;
  logic [15:0] cmp_buf_a_reg;
  logic [15:0] cmp_buf_a_next;
  logic [15:0] cmp_buf_b_reg;
  logic [15:0] cmp_buf_b_next;
  logic [15:0] compare_value_a_reg;
  logic [15:0] compare_value_a_next;
  logic [15:0] compare_value_b_reg;
  logic [15:0] compare_value_b_next;
  logic [15:0] capture_value_reg;
  logic [15:0] capture_value_next;
  logic [2:0]  status_reg;
  logic [2:0]  status_next;
  logic [2:0]  mask_reg;
  logic [2:0]  mask_next;
  logic [15:0] presc_reg;
  logic [15:0] presc_next;
  logic [15:0] presc_cnt_reg;
  logic [15:0] presc_cnt_next;
  logic        dir_up_reg;
  logic        dir_up_next;
  logic        tick;

  logic [3:0]  waveform_mode_sel;
  logic [1:0]  chan_a_output_action;
  logic [1:0]  chan_b_output_action;
  tmw_pkg::tmw_seq_e    seq;
  tmw_pkg::tmw_topsrc_e topsrc;
  tmw_pkg::tmw_reload_e reload;
  logic [15:0] top_fixed;
  logic [15:0] top_val;
  logic        ovf_at_max;
  logic        at_top;
  logic        at_floor;
  logic        match_a;
  logic        match_b;
  logic        overflow_flag;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic        addr_ok;
  logic        lvl_a;
  logic        lvl_b;
  logic        con_a;
  logic        con_b;
  logic        den_a;
  logic        den_b;

  assign chan_a_output_action = timer_waveform_control_a_reg[`TMW_ACT_A_HI:`TMW_ACT_A_LO];
  assign chan_b_output_action = timer_waveform_control_a_reg[`TMW_ACT_B_HI:`TMW_ACT_B_LO];
  assign waveform_mode_sel    = {mode_hi_reg, timer_waveform_control_a_reg[1:0]};

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    seq        = tmw_pkg::TMW_SEQ_NONE;
    topsrc     = tmw_pkg::TMW_TOP_FIXED;
    reload     = tmw_pkg::TMW_RELOAD_NOW;
    top_fixed  = `TMW_MAX;
    ovf_at_max = 1'b0;
    case (waveform_mode_sel)
      4'h0: begin
        seq        = tmw_pkg::TMW_SEQ_UP;
        ovf_at_max = 1'b1;
      end
      4'h4, 4'hC: begin
        seq        = tmw_pkg::TMW_SEQ_UP;
        topsrc     = waveform_mode_sel[3] ? tmw_pkg::TMW_TOP_CAP : tmw_pkg::TMW_TOP_CMPA;
        ovf_at_max = 1'b1;
      end
      4'h1, 4'h2, 4'h3: begin
        seq       = tmw_pkg::TMW_SEQ_DUAL;
        reload    = tmw_pkg::TMW_RELOAD_TOP;
        top_fixed = (waveform_mode_sel[1:0] == 2'h1) ? `TMW_TOP_8BIT :
                    (waveform_mode_sel[1:0] == 2'h2) ? `TMW_TOP_9BIT : `TMW_TOP_10BIT;
      end
      4'hA, 4'hB: begin
        seq    = tmw_pkg::TMW_SEQ_DUAL;
        reload = tmw_pkg::TMW_RELOAD_TOP;
        topsrc = waveform_mode_sel[0] ? tmw_pkg::TMW_TOP_CMPA : tmw_pkg::TMW_TOP_CAP;
      end
      4'h8, 4'h9: begin
        seq    = tmw_pkg::TMW_SEQ_DUAL;
        reload = tmw_pkg::TMW_RELOAD_FLOOR;
        topsrc = waveform_mode_sel[0] ? tmw_pkg::TMW_TOP_CMPA : tmw_pkg::TMW_TOP_CAP;
      end
      4'h5, 4'h6, 4'h7: begin
        seq       = tmw_pkg::TMW_SEQ_FAST;
        reload    = tmw_pkg::TMW_RELOAD_TOP;
        top_fixed = (waveform_mode_sel[1:0] == 2'h1) ? `TMW_TOP_8BIT :
                    (waveform_mode_sel[1:0] == 2'h2) ? `TMW_TOP_9BIT : `TMW_TOP_10BIT;
      end
      4'hE, 4'hF: begin
        seq    = tmw_pkg::TMW_SEQ_FAST;
        reload = tmw_pkg::TMW_RELOAD_TOP;
        topsrc = waveform_mode_sel[0] ? tmw_pkg::TMW_TOP_CMPA : tmw_pkg::TMW_TOP_CAP;
      end
      // Reserved setting stops the counter rather than guess a sequence
      default: seq = tmw_pkg::TMW_SEQ_NONE;
    endcase
  end

  always_comb begin
    case (topsrc)
      tmw_pkg::TMW_TOP_CMPA: top_val = compare_value_a_reg;
      tmw_pkg::TMW_TOP_CAP:  top_val = capture_value_reg;
      default:               top_val = top_fixed;
    endcase
  end

  assign at_top   = (counter_value_reg == top_val);
  assign at_floor = (counter_value_reg == `TMW_FLOOR);
  assign match_a  = (counter_value_reg == compare_value_a_reg);
  assign match_b  = (counter_value_reg == compare_value_b_reg);
  assign tick     = (presc_cnt_reg == presc_reg);

  // ----------------------------------------------------------------
  // Counter, prescaler, compare buffers
  // ----------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    presc_cnt_next       = tick ? 16'h0000 : presc_cnt_reg + 16'h0001;
    counter_value_next   = counter_value_reg;
    dir_up_next          = dir_up_reg;
    overflow_flag        = 1'b0;
    compare_value_a_next = compare_value_a_reg;
    compare_value_b_next = compare_value_b_reg;
    if (tick) begin
      case (seq)
        tmw_pkg::TMW_SEQ_UP, tmw_pkg::TMW_SEQ_FAST: begin
          counter_value_next = at_top ? `TMW_FLOOR : counter_value_reg + 16'h0001;
          overflow_flag      = ovf_at_max ? (counter_value_reg == `TMW_MAX) : at_top;
        end
        tmw_pkg::TMW_SEQ_DUAL: begin
          // One tick at ceiling, then turn round
          if (dir_up_reg && at_top) begin
            dir_up_next        = 1'b0;
            counter_value_next = counter_value_reg - 16'h0001;
          end else if (!dir_up_reg && at_floor) begin
            dir_up_next        = 1'b1;
            counter_value_next = counter_value_reg + 16'h0001;
          end else begin
            counter_value_next = dir_up_reg ? counter_value_reg + 16'h0001
                                            : counter_value_reg - 16'h0001;
          end
          overflow_flag = at_floor;
        end
        default: counter_value_next = counter_value_reg;
      endcase
      if ((reload == tmw_pkg::TMW_RELOAD_TOP && at_top) ||
          (reload == tmw_pkg::TMW_RELOAD_FLOOR && at_floor)) begin
        compare_value_a_next = cmp_buf_a_reg;
        compare_value_b_next = cmp_buf_b_reg;
      end
    end
    if (reload == tmw_pkg::TMW_RELOAD_NOW) begin
      compare_value_a_next = cmp_buf_a_reg;
      compare_value_b_next = cmp_buf_b_reg;
    end
    if (wr_en && paddr == `TMW_CNT_OFF)
      counter_value_next = pwdata[15:0];
  end

  // ----------------------------------------------------------------
  // APB register writes and status
  // ----------------------------------------------------------------
  always_comb begin
    timer_waveform_control_a_next = timer_waveform_control_a_reg;
    mode_hi_next       = mode_hi_reg;
    cmp_buf_a_next     = cmp_buf_a_reg;
    cmp_buf_b_next     = cmp_buf_b_reg;
    capture_value_next = capture_value_reg;
    mask_next          = mask_reg;
    presc_next         = presc_reg;
    status_next        = status_reg;
    if (rd_en && paddr == `TMW_STAT_OFF)
      status_next = 3'h0;
    // Hardware set wins over the read clear
    status_next[`TMW_STAT_OVF]     = status_next[`TMW_STAT_OVF] | overflow_flag;
    status_next[`TMW_STAT_MATCH_A] = status_next[`TMW_STAT_MATCH_A] | (tick & match_a);
    status_next[`TMW_STAT_MATCH_B] = status_next[`TMW_STAT_MATCH_B] | (tick & match_b);
    if (wr_en) begin
      case (paddr)
        `TMW_CTRL_A_OFF: timer_waveform_control_a_next = pwdata[7:0] & `TMW_CTRL_A_MASK;
        `TMW_CTRL_B_OFF: mode_hi_next       = pwdata[1:0];
        `TMW_CMPA_OFF:   cmp_buf_a_next     = pwdata[15:0];
        `TMW_CMPB_OFF:   cmp_buf_b_next     = pwdata[15:0];
        `TMW_CAP_OFF:    capture_value_next = pwdata[15:0];
        `TMW_MASK_OFF:   mask_next          = pwdata[2:0];
        `TMW_PRESC_OFF:  presc_next         = pwdata[15:0];
        default:         mask_next          = mask_reg;
      endcase
    end
  end

  always_comb begin
    addr_ok = 1'b1;
    rdata   = 32'h0000_0000;
    case (paddr)
      `TMW_CTRL_A_OFF: rdata = {24'h000000, timer_waveform_control_a_reg};
      `TMW_CTRL_B_OFF: rdata = {30'h00000000, mode_hi_reg};
      `TMW_CNT_OFF:    rdata = {16'h0000, counter_value_reg};
      `TMW_CMPA_OFF:   rdata = {16'h0000, cmp_buf_a_reg};
      `TMW_CMPB_OFF:   rdata = {16'h0000, cmp_buf_b_reg};
      `TMW_CAP_OFF:    rdata = {16'h0000, capture_value_reg};
      `TMW_STAT_OFF:   rdata = {29'h00000000, status_next};
      `TMW_MASK_OFF:   rdata = {29'h00000000, mask_reg};
      `TMW_PRESC_OFF:  rdata = {16'h0000, presc_reg};
      default:         addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_waveform_control_a_reg <= `TMW_CTRL_A_RST;
      mode_hi_reg         <= 2'h0;
      counter_value_reg   <= 16'h0000;
      cmp_buf_a_reg       <= 16'h0000;
      cmp_buf_b_reg       <= 16'h0000;
      compare_value_a_reg <= 16'h0000;
      compare_value_b_reg <= 16'h0000;
      capture_value_reg   <= 16'h0000;
      status_reg          <= 3'h0;
      mask_reg            <= 3'h0;
      presc_reg           <= `TMW_PRESC_RST;
      presc_cnt_reg       <= 16'h0000;
      dir_up_reg          <= 1'b1;
      pready              <= 1'b0;
      prdata              <= 32'h0000_0000;
      pslverr             <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      timer_waveform_control_a_reg <= timer_waveform_control_a_next;
      mode_hi_reg         <= mode_hi_next;
      counter_value_reg   <= counter_value_next;
      cmp_buf_a_reg       <= cmp_buf_a_next;
      cmp_buf_b_reg       <= cmp_buf_b_next;
      compare_value_a_reg <= compare_value_a_next;
      compare_value_b_reg <= compare_value_b_next;
      capture_value_reg   <= capture_value_next;
      status_reg          <= status_next;
      mask_reg            <= mask_next;
      presc_reg           <= presc_next;
      presc_cnt_reg       <= presc_cnt_next;
      dir_up_reg          <= dir_up_next;
      // Zero-wait answer: pready is high in every access phase
      pready              <= 1'b1;
      prdata              <= (psel && !penable && !pwrite) ? rdata : prdata;
      pslverr             <= 1'b0;
      irq                 <= |(status_next & mask_next);
    end
  end

  // Combinational APB outputs would break the flop-only output style, so
  // pready is held high; data is sampled in the setup phase and presented in the access phase.
  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  tmw_channel u_chan_a (
    .pclk         (pclk),
    .presetn      (presetn),
    .action       (chan_a_output_action),
    .is_chan_a    (1'b1),
    .mode         (waveform_mode_sel),
    .seq          (seq),
    .tick         (tick),
    .match        (match_a),
    .at_top       (at_top),
    .counting_up  (dir_up_reg),
    .cmp_is_top   (compare_value_a_reg == top_val),
    .cmp_is_floor (compare_value_a_reg == `TMW_FLOOR),
    .ddr_out      (ddr_out_a),
    .level        (lvl_a),
    .connect      (con_a),
    .drive_en     (den_a)
  );

  tmw_channel u_chan_b (
    .pclk         (pclk),
    .presetn      (presetn),
    .action       (chan_b_output_action),
    .is_chan_a    (1'b0),
    .mode         (waveform_mode_sel),
    .seq          (seq),
    .tick         (tick),
    .match        (match_b),
    .at_top       (at_top),
    .counting_up  (dir_up_reg),
    .cmp_is_top   (compare_value_b_reg == top_val),
    .cmp_is_floor (compare_value_b_reg == `TMW_FLOOR),
    .ddr_out      (ddr_out_b),
    .level        (lvl_b),
    .connect      (con_b),
    .drive_en     (den_b)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_out_a     <= 1'b0;
      compare_out_a_oe  <= 1'b0;
      compare_out_a_sel <= 1'b0;
      compare_out_b     <= 1'b0;
      compare_out_b_oe  <= 1'b0;
      compare_out_b_sel <= 1'b0;
    end else begin
      compare_out_a     <= lvl_a;
      compare_out_a_sel <= con_a;
      compare_out_a_oe  <= con_a && den_a;
      compare_out_b     <= lvl_b;
      compare_out_b_sel <= con_b;
      compare_out_b_oe  <= con_b && den_b;
    end
  end
endmodule
